// ### rtl/ldd_pkg.sv
// Purpose: shared constants for the lane deskew and disparity status block
// Assumes: 32-bit avalon-mm register bus, byte addresses are four times the index
// Notes: register index values keep the printed offsets
package ldd_pkg;
  localparam int unsigned LANES = 8;
  localparam int unsigned LINKS = 2;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 32;

  // register indices; byte address is index * 4
  localparam logic [ADDR_W-1:0] IDX_LINK_PAGE = 13'h0300;
  localparam logic [ADDR_W-1:0] IDX_DESKEW = 13'h046C;
  localparam logic [ADDR_W-1:0] IDX_DISPARITY = 13'h046D;
  localparam logic [ADDR_W-1:0] IDX_THRESHOLD = 13'h04F0;
  localparam logic [ADDR_W-1:0] IDX_CNT_CLEAR = 13'h04F1;

  localparam logic [7:0] THRESHOLD_RST = 8'hFF;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [0:0] PAGE_RST = 1'h0;
  localparam int unsigned CLEAR_BIT = 0;
endpackage : ldd_pkg

// ### rtl/ldd_lane_ctr.sv
// Purpose: one lane's saturating disparity error counter and threshold flag
// Assumes: error event is a one-cycle pulse from logic on ref_clk
// Notes: a new error in the clear cycle is kept as a count of one
`timescale 1ns/100ps
module ldd_lane_ctr #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic err_evt,
  input wire logic cnt_clr,
  input wire logic [CNT_W-1:0] threshold,
  output logic flag
);
  logic [CNT_W-1:0] cnt_q;
  logic flag_q;
  logic [CNT_W-1:0] cnt_max;

  assign cnt_max = {CNT_W{1'b1}};

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (cnt_clr)
      begin
        // set wins over clear: the colliding event is counted
        cnt_q <= err_evt ? CNT_W'(1) : '0;
      end
      else if (err_evt && cnt_q != cnt_max)
      begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // registered compare keeps the flag at zero through reset even with a zero threshold
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      flag_q <= 1'b0;
    end
    else if (ce)
    begin
      flag_q <= (cnt_q >= threshold);
    end
  end

  assign flag = flag_q;
endmodule : ldd_lane_ctr

// ### rtl/ldd_lane_status.sv
// Purpose: per-link, per-lane deskew and bad disparity status with register access
// Assumes: deskew levels and error pulses come from receiver logic on ref_clk
// Notes: one wait state on every bus access; unmapped reads return zero
`timescale 1ns/100ps

// Overview of operation
// - read-only deskew bit per lane, 1 achieved
// - disparity flag set when count reaches threshold
// - status read from link chosen by page
// - status bits read-only, reset to zero
// - disparity register bit n is lane n
module ldd_lane_status #(
  parameter int unsigned LANES = ldd_pkg::LANES,
  parameter int unsigned LINKS = ldd_pkg::LINKS,
  parameter int unsigned CNT_W = ldd_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // receiver side, one lane group per link, link k at [k*LANES +: LANES]
  input wire logic [LINKS*LANES-1:0] deskew_ok_in,
  input wire logic [LINKS*LANES-1:0] disparity_err_evt,
  // avalon-mm slave, byte address
  input wire logic [ldd_pkg::ADDR_W+1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ldd_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ldd_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // current status of the selected link and the shared threshold, for on-chip users
  output logic [LANES-1:0] deskew_ok_sel,
  output logic [LANES-1:0] disparity_flag_sel,
  output logic [CNT_W-1:0] error_count_threshold
);
  localparam int unsigned PAGE_W = (LINKS > 1) ? $clog2(LINKS) : 1;

  logic ack_q;
  logic [ldd_pkg::DATA_W-1:0] rdata_q;
  logic [PAGE_W-1:0] link_page_q;
  logic [CNT_W-1:0] threshold_q;
  logic [LINKS-1:0] clr_q;
  logic [LINKS*LANES-1:0] deskew_q;
  logic [LINKS*LANES-1:0] disp_flag;
  logic [ldd_pkg::ADDR_W-1:0] idx;
  logic req;
  logic wr_take;
  logic hit_page;
  logic hit_deskew;
  logic hit_disp;
  logic hit_thr;
  logic hit_clr;
  logic [ldd_pkg::DATA_W-1:0] rd_mux;
  logic [LANES-1:0] page_deskew;
  logic [LANES-1:0] page_disp;

  assign idx = avs_address[ldd_pkg::ADDR_W+1:2];
  assign req = avs_read | avs_write;
  assign hit_page = (idx == ldd_pkg::IDX_LINK_PAGE);
  assign hit_deskew = (idx == ldd_pkg::IDX_DESKEW);
  assign hit_disp = (idx == ldd_pkg::IDX_DISPARITY);
  assign hit_thr = (idx == ldd_pkg::IDX_THRESHOLD);
  assign hit_clr = (idx == ldd_pkg::IDX_CNT_CLEAR);
  // write lands only at the edge where waitrequest is seen low
  assign wr_take = avs_write & ack_q & avs_byteenable[0];

  // every request waits exactly one cycle; a frozen clock enable keeps the master waiting
  assign avs_waitrequest = req & ~(ack_q & ce);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
    end
    else if (ce)
    begin
      ack_q <= req & ~ack_q;
    end
  end

  // deskew status per link; follows the receiver, nothing software writes reaches it
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      deskew_q <= '0;
    end
    else if (ce)
    begin
      deskew_q <= deskew_ok_in;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      link_page_q <= PAGE_W'(ldd_pkg::PAGE_RST);
    end
    else if (ce && wr_take && hit_page)
    begin
      link_page_q <= avs_writedata[PAGE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      threshold_q <= CNT_W'(ldd_pkg::THRESHOLD_RST);
    end
    else if (ce && wr_take && hit_thr)
    begin
      threshold_q <= avs_writedata[CNT_W-1:0];
    end
  end

  // counter clear is a one-cycle strobe aimed at the paged link only
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      clr_q <= '0;
    end
    else if (ce)
    begin
      clr_q <= '0;
      if (wr_take && hit_clr && avs_writedata[ldd_pkg::CLEAR_BIT])
      begin
        clr_q[link_page_q] <= 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LINKS*LANES; gi++)
    begin : g_lane
      ldd_lane_ctr #(
        .CNT_W(CNT_W)
      ) u_ctr (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .err_evt(disparity_err_evt[gi]),
        .cnt_clr(clr_q[gi / LANES]),
        .threshold(threshold_q),
        .flag(disp_flag[gi])
      );
    end
  endgenerate

  // each link keeps its own copy; the page picks which one is seen
  assign page_deskew = deskew_q[link_page_q*LANES +: LANES];
  assign page_disp = disp_flag[link_page_q*LANES +: LANES];

  always_comb
  begin
    rd_mux = '0;
    if (hit_page)
    begin
      rd_mux[PAGE_W-1:0] = link_page_q;
    end
    else if (hit_deskew)
    begin
      rd_mux[LANES-1:0] = page_deskew;
    end
    else if (hit_disp)
    begin
      rd_mux[LANES-1:0] = page_disp;
    end
    else if (hit_thr)
    begin
      rd_mux[CNT_W-1:0] = threshold_q;
    end
  end

  // read data captured in the wait cycle, stands at the release edge
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rdata_q <= '0;
    end
    else if (ce && avs_read && !ack_q)
    begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata = rdata_q;
  assign deskew_ok_sel = page_deskew;
  assign disparity_flag_sel = page_disp;
  assign error_count_threshold = threshold_q;
endmodule : ldd_lane_status

// ### tb/ldd_tx_model.sv
// Purpose: upstream link model, deskew levels and error pulses
// Assumes: ref_clk domain, pulses one cycle each
// Notes: outputs change only just after an edge
`timescale 1ns/100ps
module ldd_tx_model (
  input wire logic ref_clk,
  input wire logic [15:0] dsk,
  input wire logic [15:0] hit,
  output logic [15:0] deskew_ok_in,
  output logic [15:0] disparity_err_evt
);
  always_ff @(posedge ref_clk)
  begin
    deskew_ok_in <= dsk;
    disparity_err_evt <= hit;
  end
endmodule : ldd_tx_model

// ### tb/ldd_lane_status_sva.sv
// Purpose: port checks of the lane status block
// Assumes: ce high
// Notes: page is internal, so reads compare with the sel outputs
`timescale 1ns/100ps
module ldd_lane_status_sva (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [15:0] deskew_ok_in,
  input wire logic [14:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] deskew_ok_sel,
  input wire logic [7:0] disparity_flag_sel,
  input wire logic [7:0] error_count_threshold
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_rd(idx);
    avs_read && !avs_waitrequest && avs_address[14:2] == idx;
  endsequence
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait state");
  a_reset_zero: assert property (disable iff (1'b0) srst && ce |=> deskew_ok_sel == 8'h00 &&
    disparity_flag_sel == 8'h00 && error_count_threshold == 8'hFF)
    else $error("status not cleared by reset");
  a_deskew_track: assert property (!srst && ce && $stable(deskew_ok_in) &&
    deskew_ok_in[15:8] == deskew_ok_in[7:0] |=> deskew_ok_sel == $past(deskew_ok_in[7:0]))
    else $error("deskew bits do not follow lanes");
  a_deskew_read: assert property (s_rd(ldd_pkg::IDX_DESKEW) |->
    avs_readdata == {24'h0, $past(deskew_ok_sel)})
    else $error("deskew read differs from paged bits");
  a_flag_read: assert property (s_rd(ldd_pkg::IDX_DISPARITY) |->
    avs_readdata == {24'h0, $past(disparity_flag_sel)})
    else $error("flag read differs from paged flags");
  a_flag_hold: assert property (!avs_write && !$past(avs_write) && !$past(avs_write, 2) |=>
    (disparity_flag_sel & $past(disparity_flag_sel)) == $past(disparity_flag_sel))
    else $error("flag dropped without a write");
endmodule : ldd_lane_status_sva
bind ldd_lane_status ldd_lane_status_sva chk (.ref_clk, .srst, .ce, .deskew_ok_in, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .deskew_ok_sel, .disparity_flag_sel,
  .error_count_threshold);

// ### tb/ldd_lane_status_bench.sv
// Purpose: register tests of the lane status block
// Assumes: ce and byteenable tied high
// Notes: lane traffic comes from the link model
`timescale 1ns/100ps
module ldd_lane_status_bench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [14:0] adr = 15'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [15:0] dsk = 16'h0;
  logic [15:0] hit = 16'h0;
  logic [15:0] dok;
  logic [15:0] evt;
  logic [31:0] rdat;
  logic wreq;
  int fails = 0;
  int tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  ldd_tx_model tx (.ref_clk, .dsk, .hit, .deskew_ok_in(dok), .disparity_err_evt(evt));
  ldd_lane_status dut (.ref_clk, .srst, .ce(1'b1), .deskew_ok_in(dok), .disparity_err_evt(evt),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq), .deskew_ok_sel(),
    .disparity_flag_sel(), .error_count_threshold());
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // waitrequest and read data are taken at the rising edge itself, before it updates them
  task automatic acc(input logic w, input logic [12:0] idx, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    logic tmo;
    n = 0;
    adr <= {idx, 2'b00};
    wdat <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    tmo = (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    // one idle edge keeps the next call from re-raising a strobe in this time step
    @(posedge ref_clk);
    if (tmo)
    begin
      fails++;
      $display("Error at %0t: bus timeout", $time);
      results();
    end
  endtask : acc
  task automatic wr_reg(input logic [12:0] idx, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, idx, d, q);
  endtask : wr_reg
  task automatic rd_chk(input logic [12:0] idx, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, idx, 32'h0, q);
    tests_run++;
    if (q !== e)
      $display("Error at %0t: reg %h read %h not %h", $time, idx, q, e);
    if (q !== e)
      fails++;
  endtask : rd_chk
  task automatic burst(input logic [15:0] m, input int n);
    repeat (n)
    begin
      hit <= m;
      @(posedge ref_clk);
    end
    hit <= 16'h0;
    repeat (3) @(posedge ref_clk);
  endtask : burst
  initial
  begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd_chk(ldd_pkg::IDX_DESKEW, 32'h0);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h0);
    rd_chk(ldd_pkg::IDX_THRESHOLD, 32'hFF);
    rd_chk(13'h0001, 32'h0);
    $display("reset test done");
    dsk <= 16'h3CA5;
    wr_reg(ldd_pkg::IDX_DESKEW, 32'hFF);
    rd_chk(ldd_pkg::IDX_DESKEW, 32'hA5);
    wr_reg(ldd_pkg::IDX_LINK_PAGE, 32'h1);
    rd_chk(ldd_pkg::IDX_DESKEW, 32'h3C);
    wr_reg(ldd_pkg::IDX_LINK_PAGE, 32'h0);
    $display("deskew test done");
    wr_reg(ldd_pkg::IDX_THRESHOLD, 32'h3);
    burst(16'h0088, 2);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h0);
    burst(16'h0088, 1);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h88);
    wr_reg(ldd_pkg::IDX_DISPARITY, 32'h0);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h88);
    wr_reg(ldd_pkg::IDX_LINK_PAGE, 32'h1);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h0);
    // past 255 a wrapping count would fall back under the threshold
    wr_reg(ldd_pkg::IDX_THRESHOLD, 32'hFF);
    burst(16'h1000, 265);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h10);
    $display("disparity test done");
    // clear only the paged link; the shared threshold keeps link 0 flagged
    wr_reg(ldd_pkg::IDX_THRESHOLD, 32'h3);
    wr_reg(ldd_pkg::IDX_CNT_CLEAR, 32'h1);
    repeat (2) @(posedge ref_clk);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h0);
    wr_reg(ldd_pkg::IDX_LINK_PAGE, 32'h0);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h88);
    $display("clear test done");
    // second reset with flags set and equal lane halves for the tracking check
    dsk <= 16'h5A5A;
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd_chk(ldd_pkg::IDX_DISPARITY, 32'h0);
    rd_chk(ldd_pkg::IDX_DESKEW, 32'h5A);
    rd_chk(ldd_pkg::IDX_LINK_PAGE, 32'h0);
    rd_chk(ldd_pkg::IDX_THRESHOLD, 32'hFF);
    $display("second reset test done");
    results();
  end
endmodule : ldd_lane_status_bench
